// File: inc/srm_pkg.sv
package srm_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 36;
	localparam int BYTE_W = 8;
	localparam int ITEM_W = 16;
	localparam int ROM_ITEMS = 11;
	localparam int FIFO_DEPTH = 32;
	localparam logic [ADDR_W-1:0] ADDR_BASE = 18'h3_0000;
	localparam int ITEM_ADDR_LSB = 8;
	localparam int ITEM_DATA_LSB = 0;
	localparam logic [ITEM_W-1:0] ROM_TABLE [ROM_ITEMS] = '{
		16'h04a0, 16'h0501, 16'he000, 16'h20e0, 16'h38e0, 16'h50e0,
		16'h68e0, 16'h80e0, 16'h98e0, 16'hb0e0, 16'hc8e0
	};

	typedef enum logic [1:0] {
		SRM_ACQUIRE,
		SRM_ISSUE,
		SRM_FINISH
	} srm_state_type;

	// requests toward the fabric master port
	typedef struct packed {
		logic masterWriteRequest;
		logic masterBusLockRequest;
		logic masterTransferValid;
		logic [ADDR_W-1:0] masterAddressBus;
		logic [DATA_W-1:0] masterWriteBus;
	} srm_req_type;
endpackage : srm_pkg

// File: rtl/srm_sequencer.sv
// Overview of operation
// - master logic runs three states: acquire, issue, finish.
// - acquire drives write request high, and lock request high except before the release write.
// - leave acquire for issue only after acknowledge seen high.
// - issue puts item address and data out, valid for one cycle.
// - issue always moves to finish on the next cycle.
// - finish drops valid and returns to acquire.
// - acquire, issue, finish repeats once per table item.
// - after the last item one more write with lock low releases bus.
// - valid never rises before acknowledge was detected.
// - lock and write stay asserted across all locked writes.
// - item high byte is address low byte plus base; low byte is data.
// - table holds 11 items read in order from index zero.
`timescale 1ns/100ps

module srm_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wrPtr;
	logic [PTR_W-1:0] rdPtr;
	logic [PTR_W:0] fill;
	wire push = ce && inValid && inReady;
	wire pop = ce && outValid && outReady;
	assign inReady = (fill < (PTR_W+1)'(DEPTH));
	assign outValid = (fill != '0);
	assign outData = store[rdPtr];

	always_ff @(posedge clk) begin
		if (push) begin
			store[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			fill <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			end
			fill <= fill + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

	chk_fifo_takes_word: assert property (@(posedge clk) disable iff (!rst_n)
		ce && inValid && fill < (PTR_W+1)'(DEPTH) |-> inReady)
		else $error("fifo refused a word while not full");
endmodule : srm_fifo

module srm_sequencer #(
	parameter int ITEMS = srm_pkg::ROM_ITEMS,
	parameter int DEPTH = srm_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic masterPortAcknowledge,
	output srm_pkg::srm_req_type masterReq,
	output logic sequenceDone
);
	localparam int IDX_W = $clog2(ITEMS + 1);
	srm_pkg::srm_state_type state;
	srm_pkg::srm_state_type next_state;
	logic [IDX_W-1:0] romIdx;
	logic [IDX_W-1:0] doneCount;
	logic releasing;
	logic [srm_pkg::ITEM_W-1:0] fifoOut;
	logic fifoValid;
	logic feedReady;

	// table reader feeds the fifo, stalled by its ready
	wire feedValid = (romIdx < IDX_W'(ITEMS));
	wire [srm_pkg::ITEM_W-1:0] romWord = srm_pkg::ROM_TABLE[romIdx < IDX_W'(ITEMS) ? romIdx : '0];
	wire takeItem = (state == srm_pkg::SRM_ACQUIRE) && masterPortAcknowledge && fifoValid
		&& !releasing && !sequenceDone;
	wire startRelease = (state == srm_pkg::SRM_ACQUIRE) && masterPortAcknowledge && releasing
		&& !sequenceDone;
	wire lastItem = (doneCount == IDX_W'(ITEMS - 1));
	wire [srm_pkg::ADDR_W-1:0] itemAddr = srm_pkg::ADDR_BASE
		| srm_pkg::ADDR_W'(fifoOut[srm_pkg::ITEM_ADDR_LSB +: srm_pkg::BYTE_W]);
	wire [srm_pkg::DATA_W-1:0] itemData = srm_pkg::DATA_W'(fifoOut[srm_pkg::ITEM_DATA_LSB +: srm_pkg::BYTE_W]);

	srm_fifo #(.WIDTH(srm_pkg::ITEM_W), .DEPTH(DEPTH)) itemFifo (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.inData(romWord),
		.inValid(feedValid),
		.inReady(feedReady),
		.outData(fifoOut),
		.outValid(fifoValid),
		.outReady(takeItem)
	);

	always_comb begin
		next_state = state;
		case (state)
			srm_pkg::SRM_ACQUIRE: begin
				if (takeItem || startRelease) begin
					next_state = srm_pkg::SRM_ISSUE;
				end
			end
			srm_pkg::SRM_ISSUE: next_state = srm_pkg::SRM_FINISH;
			srm_pkg::SRM_FINISH: next_state = srm_pkg::SRM_ACQUIRE;
			default: next_state = srm_pkg::SRM_ACQUIRE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			romIdx <= '0;
		end else if (ce && feedValid && feedReady) begin
			romIdx <= romIdx + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= srm_pkg::SRM_ACQUIRE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			doneCount <= '0;
			releasing <= 1'b0;
			sequenceDone <= 1'b0;
		end else if (ce && state == srm_pkg::SRM_FINISH) begin
			if (releasing) begin
				sequenceDone <= 1'b1;
			end else begin
				doneCount <= doneCount + 1'b1;
				releasing <= lastItem;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			masterReq <= '0;
		end else if (ce) begin
			masterReq.masterWriteRequest <= !sequenceDone
				&& !(state == srm_pkg::SRM_FINISH && releasing);
			masterReq.masterBusLockRequest <= !sequenceDone && !releasing
				&& !(state == srm_pkg::SRM_FINISH && lastItem);
			masterReq.masterTransferValid <= (next_state == srm_pkg::SRM_ISSUE);
			if (takeItem) begin
				masterReq.masterAddressBus <= itemAddr;
				masterReq.masterWriteBus <= itemData;
			end
		end
	end

	chk_valid_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
		ce && masterReq.masterTransferValid |=> !masterReq.masterTransferValid)
		else $error("transfer valid held more than one cycle");
	chk_valid_after_ack: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(masterReq.masterTransferValid) |-> $past(masterPortAcknowledge))
		else $error("transfer valid without prior acknowledge");
	chk_issue_to_finish: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state == srm_pkg::SRM_ISSUE |=> state == srm_pkg::SRM_FINISH)
		else $error("issue did not move to finish");
	chk_finish_to_acquire: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state == srm_pkg::SRM_FINISH |=> state == srm_pkg::SRM_ACQUIRE && !masterReq.masterTransferValid)
		else $error("finish did not return to acquire");
	chk_acquire_requests: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && state == srm_pkg::SRM_ACQUIRE && !sequenceDone && $past(ce)
		&& $past(state) == srm_pkg::SRM_ACQUIRE
		&& !releasing |-> masterReq.masterWriteRequest && masterReq.masterBusLockRequest)
		else $error("acquire without write and lock requests");
	chk_locked_writes: assert property (@(posedge clk) disable iff (!rst_n)
		masterReq.masterTransferValid && !releasing |-> masterReq.masterWriteRequest
		&& masterReq.masterBusLockRequest)
		else $error("lock or write dropped during locked write");
	chk_release_write: assert property (@(posedge clk) disable iff (!rst_n)
		masterReq.masterTransferValid && releasing |-> masterReq.masterWriteRequest
		&& !masterReq.masterBusLockRequest)
		else $error("release write still locked");
	chk_address_base: assert property (@(posedge clk) disable iff (!rst_n)
		masterReq.masterTransferValid |-> masterReq.masterAddressBus[srm_pkg::ADDR_W-1:srm_pkg::BYTE_W]
		== srm_pkg::ADDR_BASE[srm_pkg::ADDR_W-1:srm_pkg::BYTE_W])
		else $error("address outside base window");
	chk_reset_idle: assert property (@(posedge clk)
		!rst_n |=> !masterReq.masterWriteRequest && !masterReq.masterBusLockRequest
		&& !masterReq.masterTransferValid)
		else $error("requests active after reset");
	chk_index_bound: assert property (@(posedge clk) disable iff (!rst_n)
		doneCount <= IDX_W'(ITEMS) && !(sequenceDone && masterReq.masterTransferValid))
		else $error("index beyond table or write after done");
	chk_wait_for_ack: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state == srm_pkg::SRM_ACQUIRE && !masterPortAcknowledge |=> state == srm_pkg::SRM_ACQUIRE)
		else $error("left acquire without acknowledge");
	chk_data_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
		masterReq.masterTransferValid |-> masterReq.masterWriteBus[srm_pkg::DATA_W-1:srm_pkg::BYTE_W] == '0)
		else $error("write data wider than one byte");
	chk_done_holds: assert property (@(posedge clk) disable iff (!rst_n)
		sequenceDone |=> sequenceDone && !masterReq.masterWriteRequest)
		else $error("activity after sequence done");
	chk_lock_drops_last: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state == srm_pkg::SRM_FINISH && lastItem && !releasing
		|=> !masterReq.masterBusLockRequest && masterReq.masterWriteRequest)
		else $error("lock not dropped after last item");
	chk_index_advance: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state == srm_pkg::SRM_FINISH && !releasing |=> doneCount == $past(doneCount) + 1'b1)
		else $error("index did not advance after write");
endmodule : srm_sequencer

// File: tb/srm_port_model.sv
`timescale 1ns/100ps

// fabric master port: acknowledges a pending write request, promptly or after a wait
module srm_port_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire srm_pkg::srm_req_type req,
	input wire logic slow,
	output logic ack
);
	logic [1:0] waitCnt;
	always_ff @(posedge clk) begin
		if (!rst_n || !req.masterWriteRequest || req.masterTransferValid) begin
			waitCnt <= 2'h0;
			ack <= 1'b0;
		end else begin
			waitCnt <= waitCnt + 2'h1;
			ack <= !slow || waitCnt == 2'h3;
		end
	end
endmodule : srm_port_model

// File: tb/srm_sequencer_tb.sv
`timescale 1ns/100ps

module srm_sequencer_tb;
	logic clk;
	logic rst_n;
	logic ce;
	logic slow;
	logic ack;
	logic sequenceDone;
	srm_pkg::srm_req_type req;
	int errorCnt;
	int checkCount;
	logic [17:0] rowAddr [srm_pkg::ROM_ITEMS];
	logic [35:0] rowData [srm_pkg::ROM_ITEMS];

	srm_sequencer u_srm_sequencer (.clk(clk), .rst_n(rst_n), .ce(ce), .masterPortAcknowledge(ack),
		.masterReq(req), .sequenceDone(sequenceDone));
	srm_port_model u_srm_port_model (.clk(clk), .rst_n(rst_n), .req(req), .slow(slow), .ack(ack));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finishTest;
		$display("checks %0d errors %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finishTest

	task automatic chk(input string name, input logic [56:0] exp, input logic [56:0] got);
		checkCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// waits at falling edges for the one-cycle valid pulse
	task automatic wait_valid;
		int n;
		n = 0;
		while (req.masterTransferValid !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 60) begin
				chk("valid timeout", 57'h1, 57'h0);
				break;
			end
		end
	endtask : wait_valid

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		slow = 1'b0;
		for (int i = 0; i < srm_pkg::ROM_ITEMS; i++) begin
			rowAddr[i] = srm_pkg::ADDR_BASE | 18'(srm_pkg::ROM_TABLE[i][15:8]);
			rowData[i] = 36'(srm_pkg::ROM_TABLE[i][7:0]);
		end
		repeat (3) @(negedge clk);
		chk("reset outputs", 57'h0, req);
		rst_n = 1'b1;
		for (int i = 0; i < srm_pkg::ROM_ITEMS; i++) begin
			slow = i[0];
			if (i == 4) begin
				ce = 1'b0;
				repeat (4) @(negedge clk);
				chk("frozen valid", 57'h0, 57'(req.masterTransferValid));
				chk("frozen address", 57'(rowAddr[i - 1]), 57'(req.masterAddressBus));
				ce = 1'b1;
			end
			wait_valid();
			chk("address", 57'(rowAddr[i]), 57'(req.masterAddressBus));
			chk("data", 57'(rowData[i]), 57'(req.masterWriteBus));
			chk("lock and write", 57'h3, 57'({req.masterBusLockRequest, req.masterWriteRequest}));
			@(negedge clk);
			chk("valid pulse", 57'h0, 57'(req.masterTransferValid));
		end
		wait_valid();
		chk("release lock", 57'h1, 57'({req.masterBusLockRequest, req.masterWriteRequest}));
		repeat (20) @(negedge clk);
		chk("done", 57'h1, 57'(sequenceDone));
		chk("idle after done", 57'h0, 57'({req.masterTransferValid, req.masterWriteRequest}));
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		chk("second reset", 57'h0, 57'({sequenceDone, req.masterWriteRequest}));
		rst_n = 1'b1;
		wait_valid();
		chk("restart address", 57'(rowAddr[0]), 57'(req.masterAddressBus));
		finishTest();
	end
endmodule : srm_sequencer_tb
